// >>> fov_far_model.sv
// Far-side model: array contents, controller status, busy level and check engine
`timescale 1ns/1ns
module fov_far_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [15:0] array_addr_in,
  input wire logic [15:0] status_set_in,
  input wire logic busy_set_in,
  input wire logic load_req_in,
  input wire logic [31:0] check_set_in,
  output logic [15:0] array_data_out,
  output logic [15:0] status_out,
  output logic busy_out,
  output logic check_load_out,
  output logic [31:0] check_value_out
);
  logic req_q;
  // Array word scrambles its address, so no two locations read alike
  assign array_data_out = array_addr_in ^ 16'hc3c3;
  assign status_out = status_set_in;
  assign busy_out = busy_set_in;
  assign check_value_out = check_set_in;
  // Request edge detect; a held request must not reload every cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_q <= 1'b0;
    end else begin
      req_q <= load_req_in;
    end
  end
  assign check_load_out = load_req_in & ~req_q;
endmodule

// >>> fov_overlay_select.sv
// Overlay space selector with APB register window and check-value register
//
// Summary of operation
// - Hold 32-bit check value as two halves
// - Overlay entry accepted only in read mode
// - Latch entry sector; reads use that sector
// - Status read command snapshots status, enters overlay
// - First status read restores previous map
// - Status only on first beat of burst
// - Beyond secure region in sector reads indeterminate
// - Other sectors read array, overlay stays
// - Secure region programmable by word or buffer
// - Legacy or common exit leaves protection overlays
// - Protection overlay entries ignore sector address
// - Configuration register at word 0, programmable
// - Password at words 0-3, readable, programmable
// - Password unlock clears global lock bit
// - Sector protect bit on bit 0
// - Program sets protect bit; erase clears all
// - Global lock bit on bit 0 everywhere
// - Program clears global lock bit
// - Software reset to read mode unless busy
`timescale 1ns/1ns
module fov_overlay_select
  import fov_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int SECT_W = 3,
  parameter int SEC_WORDS = 8,
  parameter logic [15:0] ID_WORD = 16'h5a3c // Arbitrary identification value
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [REG_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [15:0] array_data_in,
  input wire logic [15:0] status_in,
  input wire logic busy_in,
  input wire logic check_load_in,
  input wire logic [31:0] check_value_in,
  output logic [ADDR_W-1:0] array_addr_out,
  output logic [7:0] overlay_out
);

  localparam int NSECT = 1 << SECT_W;
  localparam int OFFW = ADDR_W - SECT_W;
  localparam int SIW = $clog2(SEC_WORDS);

  // Refuse shapes the decode cannot serve
  if (SECT_W < 1 || OFFW <= SIW || SIW < 1 || (1 << SIW) != SEC_WORDS || ADDR_W > 32) begin : g_chk
    $error("fov_overlay_select: unsupported parameter set");
  end

  typedef struct packed {
    fov_ov_t ov;
    fov_ov_t saved;
    logic [SECT_W-1:0] sect;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic [15:0] stat;
    logic stat_burst;
    logic [3:0] beat;
    logic [SEC_WORDS-1:0][15:0] sec;
    logic [15:0] cfg;
    logic [3:0][15:0] pwd;
    logic [NSECT-1:0] persistent_sector_protect_bit;
    logic lock;
    logic [31:0] check;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } fov_state_t;

  localparam fov_state_t ST_RST = '{
    ov: OV_READ,
    saved: OV_READ,
    lock: LOCK_RST,
    cfg: CFG_RST,
    default: '0
  };

  fov_state_t s_q;
  fov_state_t s_d;

  // Sector field of a word address
  function automatic logic [SECT_W-1:0] sect_of(input logic [ADDR_W-1:0] a);
    sect_of = a[ADDR_W-1 -: SECT_W];
  endfunction

  // Address falls in the secure words of the latched sector
  function automatic logic sec_hit(input logic [ADDR_W-1:0] a, input logic [SECT_W-1:0] s);
    sec_hit = (sect_of(a) == s) && (a[OFFW-1:SIW] == '0);
  endfunction

  // Protection overlays that the two exit commands close
  function automatic logic exitable(input fov_ov_t o);
    exitable = (o == OV_SEC) || (o == OV_CFG) || (o == OV_PWD) || (o == OV_PPB) ||
      (o == OV_LOCK);
  endfunction

  logic setup;
  logic access;
  logic cmd_wr;
  logic data_rd;
  logic read_mode;
  logic [7:0] code;
  logic [15:0] flash_word;
  logic [SIW-1:0] sidx;

  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in && s_q.ready;
  assign cmd_wr = access && pwrite_in && (paddr_in == OFF_CMD);
  assign data_rd = access && !pwrite_in && (paddr_in == OFF_RDATA);
  assign code = pwdata_in[7:0];
  assign read_mode = (s_q.ov == OV_READ) && !busy_in;
  assign sidx = s_q.addr[SIW-1:0];

  // Word seen by a flash read at the held address
  always_comb begin
    flash_word = array_data_in;
    case (s_q.ov)
      OV_READ: begin
        flash_word = array_data_in;
      end
      OV_ID: begin
        if (sect_of(s_q.addr) == s_q.sect) begin
          flash_word = (s_q.addr[OFFW-1:0] == '0) ? ID_WORD : ID_ZERO_WORD;
        end
      end
      OV_STAT: begin
        flash_word = (s_q.beat == '0) ? s_q.stat : INDET_WORD;
      end
      OV_SEC: begin
        if (sect_of(s_q.addr) == s_q.sect) begin
          flash_word = sec_hit(s_q.addr, s_q.sect) ? s_q.sec[sidx] : INDET_WORD;
        end else begin
          flash_word = array_data_in;
        end
      end
      OV_CFG: begin
        flash_word = (s_q.addr == '0) ? s_q.cfg : INDET_WORD;
      end
      OV_PWD: begin
        flash_word = (s_q.addr[ADDR_W-1:2] == '0) ? s_q.pwd[s_q.addr[1:0]] : INDET_WORD;
      end
      OV_PPB: begin
        flash_word = {15'h0000, s_q.persistent_sector_protect_bit[sect_of(s_q.addr)]};
      end
      OV_LOCK: begin
        flash_word = {15'h0000, s_q.lock};
      end
      default: begin
        flash_word = INDET_WORD;
      end
    endcase
    // Later beats after a status read stay indeterminate
    if (s_q.stat_burst && s_q.beat != '0) begin
      flash_word = INDET_WORD;
    end
  end

  // Next state: bus answer, commands, read side effects
  always_comb begin
    s_d = s_q;
    // Answer one cycle after setup; data prepared in setup
    s_d.ready = setup;
    // Error flag lives only for the answer cycle, so the pin is a plain flop
    s_d.err = 1'b0;
    if (setup) begin
      s_d.err = 1'b0;
      s_d.rdata = '0;
      case (paddr_in)
        OFF_ADDR: s_d.rdata = 32'(s_q.addr);
        OFF_CMD: s_d.rdata = '0;
        OFF_WDATA: s_d.rdata = {16'h0000, s_q.wdata};
        OFF_RDATA: s_d.rdata = {16'h0000, flash_word};
        OFF_OVERLAY: s_d.rdata = {16'h0000, 8'(s_q.sect), s_q.ov};
        OFF_CHECK_LO: s_d.rdata = {16'h0000, s_q.check[CHECK_LO_LSB +: 16]};
        OFF_CHECK_HI: s_d.rdata = {16'h0000, s_q.check[CHECK_HI_LSB +: 16]};
        OFF_STATUS: s_d.rdata = {16'h0000, s_q.stat};
        default: s_d.err = 1'b1;
      endcase
    end
    // Check value loads from the computing engine
    if (check_load_in) begin
      s_d.check = check_value_in;
    end
    // Plain register writes; a new address starts a new burst
    if (access && pwrite_in && paddr_in == OFF_ADDR) begin
      s_d.addr = pwdata_in[ADDR_W-1:0];
      s_d.beat = '0;
      s_d.stat_burst = 1'b0;
    end
    if (access && pwrite_in && paddr_in == OFF_WDATA) begin
      s_d.wdata = pwdata_in[15:0];
    end
    // Flash read: beat count and status overlay exit only
    if (data_rd) begin
      if (s_q.beat != 4'hf) begin
        s_d.beat = s_q.beat + 4'h1;
      end
      if (s_q.ov == OV_STAT) begin
        s_d.ov = s_q.saved;
        s_d.stat_burst = 1'b1;
      end
    end
    // Command decode
    if (cmd_wr) begin
      case (code)
        CMD_ID_ENTRY: begin
          if (read_mode) begin
            s_d.ov = OV_ID;
            s_d.sect = sect_of(s_q.addr);
          end
        end
        CMD_SEC_ENTRY: begin
          if (read_mode) begin
            s_d.ov = OV_SEC;
            s_d.sect = sect_of(s_q.addr);
          end
        end
        CMD_CFG_ENTRY: begin
          if (read_mode) s_d.ov = OV_CFG;
        end
        CMD_PWD_ENTRY: begin
          if (read_mode) s_d.ov = OV_PWD;
        end
        CMD_PPB_ENTRY: begin
          if (read_mode) s_d.ov = OV_PPB;
        end
        CMD_LOCK_ENTRY: begin
          if (read_mode) s_d.ov = OV_LOCK;
        end
        CMD_STATUS_READ: begin
          // Host reads before its next command, so one saved map suffices
          if (s_q.ov != OV_STAT) begin
            s_d.saved = s_q.ov;
            s_d.stat = status_in;
            s_d.ov = OV_STAT;
            s_d.beat = '0;
            s_d.stat_burst = 1'b0;
          end
        end
        CMD_RESET: begin
          if (!busy_in) begin
            s_d.ov = OV_READ;
            s_d.stat_burst = 1'b0;
          end
        end
        CMD_LEGACY_EXIT, CMD_COMMON_EXIT: begin
          if (exitable(s_q.ov)) s_d.ov = OV_READ;
        end
        CMD_WORD_PROG, CMD_BUF_PROG: begin
          case (s_q.ov)
            OV_SEC: begin
              if (sec_hit(s_q.addr, s_q.sect)) s_d.sec[sidx] = s_q.wdata;
            end
            OV_CFG: begin
              if (code == CMD_WORD_PROG && s_q.addr == '0) s_d.cfg = s_q.wdata;
            end
            OV_PWD: begin
              if (code == CMD_WORD_PROG && s_q.addr[ADDR_W-1:2] == '0) begin
                s_d.pwd[s_q.addr[1:0]] = s_q.wdata;
              end
            end
            OV_PPB: begin
              if (code == CMD_WORD_PROG) s_d.persistent_sector_protect_bit[sect_of(s_q.addr)] = 1'b1;
            end
            OV_LOCK: begin
              if (code == CMD_WORD_PROG) s_d.lock = 1'b0;
            end
            default: begin
              s_d.lock = s_q.lock;
            end
          endcase
        end
        CMD_PPB_ERASE: begin
          if (s_q.ov == OV_PPB) s_d.persistent_sector_protect_bit = '0;
        end
        CMD_PWD_UNLOCK: begin
          if (s_q.ov == OV_PWD) s_d.lock = 1'b0;
        end
        default: begin
          s_d.ov = s_d.ov;
        end
      endcase
    end
  end

  // State register; one-hot overlay code keeps a single overlay live
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops
  assign prdata_out = s_q.rdata;
  assign pready_out = s_q.ready;
  assign pslverr_out = s_q.err;
  assign array_addr_out = s_q.addr;
  assign overlay_out = s_q.ov;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  one_overlay_a: assert property ($onehot(s_q.ov))
    else $error("overlay code not one-hot");

  entry_gate_a: assert property (
    (cmd_wr && !read_mode && (code == CMD_ID_ENTRY || code == CMD_SEC_ENTRY ||
      code == CMD_CFG_ENTRY || code == CMD_PWD_ENTRY || code == CMD_PPB_ENTRY ||
      code == CMD_LOCK_ENTRY)) |=> (s_q.ov == $past(s_q.ov))
  )
    else $error("entry switched overlay outside read mode");

  status_snap_a: assert property (
    (cmd_wr && code == CMD_STATUS_READ && s_q.ov != OV_STAT)
      |=> (s_q.ov == OV_STAT && s_q.stat == $past(status_in))
  )
    else $error("status not captured on status read command");

  status_exit_a: assert property (
    (data_rd && s_q.ov == OV_STAT) |=> (s_q.ov == $past(s_q.saved))
  )
    else $error("status read did not restore previous map");

  sec_keep_a: assert property (
    (data_rd && s_q.ov == OV_SEC) |=> (s_q.ov == OV_SEC) [*2]
  )
    else $error("secure overlay ended by a read");

  reset_cmd_a: assert property (
    (cmd_wr && code == CMD_RESET) |=> (s_q.ov == ($past(busy_in) ? $past(s_q.ov) : OV_READ))
  )
    else $error("software reset handled wrongly");

  lock_read_a: assert property (
    (setup && paddr_in == OFF_RDATA && s_q.ov == OV_LOCK && !s_q.stat_burst)
      |=> (prdata_out == {31'h00000000, $past(s_q.lock)}) && pready_out
  )
    else $error("lock overlay read wrong");

  ppb_erase_a: assert property (
    (cmd_wr && code == CMD_PPB_ERASE && s_q.ov == OV_PPB) |=> (s_q.persistent_sector_protect_bit == '0)
  )
    else $error("protect bits not cleared by erase");

  unlock_a: assert property (
    (cmd_wr && code == CMD_PWD_UNLOCK && s_q.ov == OV_PWD) |=> !s_q.lock
  )
    else $error("unlock left global lock set");

  check_load_a: assert property (
    check_load_in |=> (s_q.check == $past(check_value_in))
  )
    else $error("check value not loaded");

  apb_ready_a: assert property ((setup) |=> pready_out ##1 !pready_out)
    else $error("apb answer timing wrong");

endmodule

// >>> fov_pkg.sv
// Shared constants and types for the flash overlay space selector
package fov_pkg;

  // Register window, APB byte offsets
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] OFF_ADDR = 8'h00;
  localparam logic [REG_AW-1:0] OFF_CMD = 8'h04;
  localparam logic [REG_AW-1:0] OFF_WDATA = 8'h08;
  localparam logic [REG_AW-1:0] OFF_RDATA = 8'h0c;
  localparam logic [REG_AW-1:0] OFF_OVERLAY = 8'h10;
  localparam logic [REG_AW-1:0] OFF_CHECK_LO = 8'h14;
  localparam logic [REG_AW-1:0] OFF_CHECK_HI = 8'h18;
  localparam logic [REG_AW-1:0] OFF_STATUS = 8'h1c;

  // Field positions
  localparam int CHECK_LO_LSB = 0;
  localparam int CHECK_HI_LSB = 16;
  localparam int OVL_SECT_LSB = 8;

  // Command codes, taken from the low byte of a command write
  localparam logic [7:0] CMD_ID_ENTRY = 8'h98;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_STATUS_READ = 8'h70;
  localparam logic [7:0] CMD_SEC_ENTRY = 8'h88;
  localparam logic [7:0] CMD_CFG_ENTRY = 8'h40;
  localparam logic [7:0] CMD_PWD_ENTRY = 8'h60;
  localparam logic [7:0] CMD_PPB_ENTRY = 8'hc0;
  localparam logic [7:0] CMD_LOCK_ENTRY = 8'h50;
  localparam logic [7:0] CMD_LEGACY_EXIT = 8'h90;
  localparam logic [7:0] CMD_COMMON_EXIT = 8'h29;
  localparam logic [7:0] CMD_WORD_PROG = 8'ha0;
  localparam logic [7:0] CMD_BUF_PROG = 8'h25;
  localparam logic [7:0] CMD_PPB_ERASE = 8'h80;
  localparam logic [7:0] CMD_PWD_UNLOCK = 8'h28;

  // Values after reset and fill values
  localparam logic LOCK_RST = 1'b1;
  localparam logic [15:0] CFG_RST = 16'hffff;
  localparam logic [15:0] INDET_WORD = 16'hffff;
  localparam logic [15:0] ID_ZERO_WORD = 16'h0000;

  // Active overlay, one-hot
  typedef enum logic [7:0] {
    OV_READ = 8'h01,
    OV_ID = 8'h02,
    OV_STAT = 8'h04,
    OV_SEC = 8'h08,
    OV_CFG = 8'h10,
    OV_PWD = 8'h20,
    OV_PPB = 8'h40,
    OV_LOCK = 8'h80
  } fov_ov_t;

endpackage

// >>> testbench.sv
// Self-checking bench for the overlay space selector
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module testbench;
  import fov_pkg::*;
  localparam logic [15:0] ID_V = 16'h5a3c; // Arbitrary identification value
  localparam logic [15:0] ARR_X = 16'hc3c3;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, last_err, busy, lreq, cload;
  logic [7:0] paddr, ovl;
  logic [31:0] pwdata, prdata, rv, cset, cval;
  logic [15:0] aaddr, adata, stat_set, stat;
  logic bsy;
  int mismatches, checks;
  logic [7:0] ent_c [4] = '{CMD_CFG_ENTRY, CMD_PWD_ENTRY, CMD_PPB_ENTRY, CMD_LOCK_ENTRY};
  logic [7:0] ent_o [4] = '{8'h10, 8'h20, 8'h40, 8'h80};
  fov_overlay_select #(.ID_WORD(ID_V)) dut_u (.clk_in(clk), .rst_in(rst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .array_data_in(adata),
    .status_in(stat), .busy_in(bsy), .check_load_in(cload), .check_value_in(cval),
    .array_addr_out(aaddr), .overlay_out(ovl));
  fov_far_model far_u (.clk_in(clk), .rst_in(rst), .array_addr_in(aaddr),
    .status_set_in(stat_set), .busy_set_in(busy), .load_req_in(lreq), .check_set_in(cset),
    .array_data_out(adata), .status_out(stat), .busy_out(bsy), .check_load_out(cload),
    .check_value_out(cval));
  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One APB transfer; request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t no ready", $time);
      give_verdict;
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, rv);
    `CHK(rv & m, e)
  endtask
  // Flash command: data, address, then code
  task automatic cmd(input logic [15:0] a, input logic [7:0] c, input logic [15:0] d);
    wr(OFF_WDATA, {16'h0, d});
    wr(OFF_ADDR, {16'h0, a});
    wr(OFF_CMD, {24'h0, c});
  endtask
  task automatic fl_chk(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
    wr(OFF_ADDR, {16'h0, a});
    rd_chk(OFF_RDATA, {16'h0, e}, {16'h0, m});
  endtask
  task automatic ov_chk(input logic [7:0] e);
    rd_chk(OFF_OVERLAY, {24'h0, e}, 32'h0000_00ff);
    `CHK(ovl, e)
  endtask
  // Main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst = 1'b1;
    busy = 1'b0;
    lreq = 1'b0;
    stat_set = 16'h0;
    cset = 32'h0;
    mismatches = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    ov_chk(8'h01);
    rd_chk(8'h20, 32'h0, 32'hffff_ffff);
    `CHK(last_err, 1'b1)
    cset <= 32'h1234_abcd;
    lreq <= 1'b1;
    @(posedge clk);
    lreq <= 1'b0;
    @(posedge clk);
    rd_chk(OFF_CHECK_LO, 32'habcd, 32'hffff_ffff);
    rd_chk(OFF_CHECK_HI, 32'h1234, 32'hffff_ffff);
    // Identification overlay on sector 2, second entry ignored
    cmd(16'h4555, CMD_ID_ENTRY, 16'h0);
    rd_chk(OFF_OVERLAY, 32'h0202, 32'hffff);
    cmd(16'h2000, CMD_SEC_ENTRY, 16'h0);
    ov_chk(8'h02);
    fl_chk(16'h4000, ID_V, 16'hffff);
    fl_chk(16'h4001, ID_ZERO_WORD, 16'hffff);
    fl_chk(16'h0010, 16'h0010 ^ ARR_X, 16'hffff);
    cmd(16'h0000, CMD_RESET, 16'h0);
    ov_chk(8'h01);
    busy <= 1'b1;
    cmd(16'h4555, CMD_ID_ENTRY, 16'h0);
    ov_chk(8'h01);
    busy <= 1'b0;
    // Secure region on sector 1
    cmd(16'h2000, CMD_SEC_ENTRY, 16'h0);
    rd_chk(OFF_OVERLAY, 32'h0108, 32'hffff);
    cmd(16'h2001, CMD_WORD_PROG, 16'h1111);
    fl_chk(16'h2001, 16'h1111, 16'hffff);
    cmd(16'h2002, CMD_BUF_PROG, 16'h2222);
    fl_chk(16'h2002, 16'h2222, 16'hffff);
    fl_chk(16'h2008, INDET_WORD, 16'hffff);
    fl_chk(16'h6000, 16'h6000 ^ ARR_X, 16'hffff);
    ov_chk(8'h08);
    // Status snapshot taken from the secure map, then restored
    stat_set <= 16'h0080;
    cmd(16'h0000, CMD_STATUS_READ, 16'h0);
    stat_set <= 16'h0011;
    ov_chk(8'h04);
    rd_chk(OFF_STATUS, 32'h0080, 32'hffff);
    fl_chk(16'h2001, 16'h0080, 16'hffff);
    rd_chk(OFF_RDATA, {16'h0, INDET_WORD}, 32'hffff);
    ov_chk(8'h08);
    cmd(16'h0000, CMD_LEGACY_EXIT, 16'h0);
    ov_chk(8'h01);
    // Protection overlays entered with a sector, left by both exits
    for (int i = 0; i < 8; i++) begin
      cmd(16'he000, ent_c[i % 4], 16'h0);
      ov_chk(ent_o[i % 4]);
      rd_chk(OFF_OVERLAY, {16'h0, 8'h01, ent_o[i % 4]}, 32'hffff);
      cmd(16'h0000, (i < 4) ? CMD_LEGACY_EXIT : CMD_COMMON_EXIT, 16'h0);
      ov_chk(8'h01);
    end
    cmd(16'h0000, CMD_CFG_ENTRY, 16'h0);
    fl_chk(16'h0000, CFG_RST, 16'hffff);
    cmd(16'h0000, CMD_WORD_PROG, 16'h1234);
    fl_chk(16'h0000, 16'h1234, 16'hffff);
    fl_chk(16'h0005, INDET_WORD, 16'hffff);
    ov_chk(8'h10);
    busy <= 1'b1;
    cmd(16'h0000, CMD_RESET, 16'h0);
    ov_chk(8'h10);
    busy <= 1'b0;
    cmd(16'h0000, CMD_RESET, 16'h0);
    ov_chk(8'h01);
    // Password store and unlock
    cmd(16'h0000, CMD_PWD_ENTRY, 16'h0);
    cmd(16'h0003, CMD_WORD_PROG, 16'h0abc);
    fl_chk(16'h0003, 16'h0abc, 16'hffff);
    fl_chk(16'h0000, 16'h0000, 16'hffff);
    cmd(16'h0000, CMD_PWD_UNLOCK, 16'h0);
    cmd(16'h0000, CMD_COMMON_EXIT, 16'h0);
    cmd(16'h0000, CMD_LOCK_ENTRY, 16'h0);
    fl_chk(16'h9abc, 16'h0, 16'h1);
    cmd(16'h0000, CMD_RESET, 16'h0);
    // Sector protect bits: set one, erase all
    cmd(16'h0000, CMD_PPB_ENTRY, 16'h0);
    fl_chk(16'h2005, 16'h0, 16'h1);
    cmd(16'h2000, CMD_WORD_PROG, 16'h0);
    fl_chk(16'h3fff, 16'h1, 16'h1);
    fl_chk(16'h4000, 16'h0, 16'h1);
    cmd(16'h0000, CMD_PPB_ERASE, 16'h0);
    fl_chk(16'h2000, 16'h0, 16'h1);
    cmd(16'h0000, CMD_RESET, 16'h0);
    // Second reset relocks; lock bit seen everywhere, then cleared
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmd(16'h0000, CMD_LOCK_ENTRY, 16'h0);
    fl_chk(16'hffff, 16'h1, 16'h1);
    fl_chk(16'h0000, 16'h1, 16'h1);
    cmd(16'h0000, CMD_WORD_PROG, 16'h0);
    fl_chk(16'h1234, 16'h0, 16'h1);
    give_verdict;
  end
endmodule
